// ### rtl/pstat_pkg.sv
// Purpose: Shared constants and types of the ingress port statistics block.
// Assumes: 32-bit APB register bus, byte addresses, one aligned word per register.
// Notes:   Counter rows hold the four counters of one port side by side.
package pstat_pkg;

  // ----------------------------------------------------------------------
  // Counter geometry
  // ----------------------------------------------------------------------
  localparam int NCNT = 4;
  localparam int CNT_W = 40;
  localparam int LO_W = 32;
  localparam int HI_W = 8;
  localparam int EVT_W = 12;
  localparam int PRIO_W = 3;
  localparam int ROW_W = NCNT * CNT_W;

  // ----------------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_EVT_MASK = 12'h000;
  localparam logic [11:0] ADDR_CLR = 12'h010;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h014;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h018;
  localparam logic [11:0] ADDR_PORT_BASE = 12'h100;
  localparam int PORT_STRIDE_SH = 6;
  localparam logic [1:0] SUB_CFG = 2'h0;
  localparam logic [1:0] SUB_LO = 2'h1;
  localparam logic [1:0] SUB_HI = 2'h2;
  localparam logic [1:0] SUB_FLAGS = 2'h3;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CFG_PRIO_LSB = 0;
  localparam int CFG_PRIO_W = 8;
  localparam int CFG_FTYPE_LSB = 8;
  localparam int CFG_FTYPE_W = 3;
  localparam int CFG_BYTE_BIT = 12;
  localparam int CFG_W = 13;
  localparam int FLG_CNT_LSB = 0;
  localparam int FLG_WRAP_LSB = 4;
  localparam int FLG_W = 8;
  localparam int IRQ_WRAP_BIT = 0;
  localparam int IRQ_CLRDONE_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int CLR_BIT = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [EVT_W-1:0] EVT_MASK_RST = 12'h000;
  localparam logic [CFG_W-1:0] CFG_RST = 13'h0000;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

  // ----------------------------------------------------------------------
  // Frame-type codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] FT_OK_NOMATCH = 3'h0;
  localparam logic [2:0] FT_OK_MATCH = 3'h1;
  localparam logic [2:0] FT_ERR_MATCH = 3'h2;
  localparam logic [2:0] FT_ANY_MATCH = 3'h3;
  localparam logic [2:0] FT_ERR_NOMATCH = 3'h4;
  localparam logic [2:0] FT_ANY_ERR = 3'h5;

  // Operation that occupies the counter update pipeline.
  typedef enum logic [1:0] {OP_FRAME, OP_SW_RD, OP_SW_WR, OP_CLR} pstat_op_t;

  // Software access sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} pstat_state_t;

endpackage

// ### rtl/pstat_mem_if.sv
// Purpose: Port bundle between the counter controller and the counter memory.
// Assumes: One read and one write per cycle.
// Notes:   Read data come out of a register one cycle after the address.
`timescale 1ns/1ns
interface pstat_mem_if #(parameter int DW = 160, parameter int AW = 3);
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  modport ctrl (output raddr, output we, output waddr, output wdata, input rdata);
  modport mem (input raddr, input we, input waddr, input wdata, output rdata);
endinterface

// ### rtl/pstat_cnt_mem.sv
// Purpose: Counter storage, one row of four counters per port.
// Assumes: Contents are undefined until the first statistics clear sweep.
// Notes:   Write-first bypass keeps back-to-back updates of one row coherent.
`timescale 1ns/1ns
module pstat_cnt_mem #(
  parameter int DEPTH = 8
) (
  input wire logic i_mclk,
  pstat_mem_if.mem mp
);

  logic [$bits(mp.wdata)-1:0] mem_arr [DEPTH];

  // ----------------------------------------------------------------------
  // Storage and registered read
  // ----------------------------------------------------------------------
  // A read of the row being written returns the new value, so a frame that
  // follows another of the same port never adds onto stale data.
  always_ff @(posedge i_mclk) begin
    if (mp.we) begin
      mem_arr[mp.waddr] <= mp.wdata;
    end
    if (mp.we && (mp.waddr == mp.raddr)) begin
      mp.rdata <= mp.wdata;
    end else begin
      mp.rdata <= mem_arr[mp.raddr];
    end
  end

endmodule // pstat_cnt_mem

// ### rtl/pstat_qual.sv
// Purpose: Qualifies one frame for one counter and gives its increment.
// Assumes: All inputs are stable in the cycle the frame is presented.
// Notes:   Purely combinational; one instance per counter index.
`timescale 1ns/1ns
module pstat_qual #(
  parameter int LEN_W = 14
) (
  input wire logic [pstat_pkg::CFG_W-1:0] i_cfg,
  input wire logic [pstat_pkg::EVT_W-1:0] i_evt_mask,
  input wire logic [pstat_pkg::EVT_W-1:0] i_events,
  input wire logic [pstat_pkg::PRIO_W-1:0] i_prio,
  input wire logic i_error,
  input wire logic [LEN_W-1:0] i_bytes,
  output logic o_count,
  output logic [LEN_W-1:0] o_inc
);

  logic match;
  logic type_ok;
  logic [pstat_pkg::CFG_PRIO_W-1:0] prio_mask;

  // Frame-type decode against error and event match.
  always_comb begin
    prio_mask = i_cfg[pstat_pkg::CFG_PRIO_LSB +: pstat_pkg::CFG_PRIO_W];
    match = |(i_evt_mask & i_events);
    unique case (i_cfg[pstat_pkg::CFG_FTYPE_LSB +: pstat_pkg::CFG_FTYPE_W])
      pstat_pkg::FT_OK_NOMATCH: type_ok = !i_error && !match;
      pstat_pkg::FT_OK_MATCH: type_ok = !i_error && match;
      pstat_pkg::FT_ERR_MATCH: type_ok = i_error && match;
      pstat_pkg::FT_ANY_MATCH: type_ok = match;
      pstat_pkg::FT_ERR_NOMATCH: type_ok = i_error && !match;
      pstat_pkg::FT_ANY_ERR: type_ok = i_error;
      default: type_ok = 1'b0;
    endcase
    o_count = prio_mask[i_prio] && type_ok;
    // Byte mode adds the length, frame mode adds one.
    o_inc = i_cfg[pstat_pkg::CFG_BYTE_BIT] ? i_bytes : LEN_W'(1);
  end

endmodule // pstat_qual

// ### rtl/pstat_top.sv
// Purpose: Ingress per-port statistics counters with an APB register slave.
// Assumes: Frame inputs come from logic on i_mclk; at most one frame per cycle.
// Notes:   Frames have priority over software counter access in the pipeline.
// Function
// - Four independent 40-bit counters per port, indexed 0 to 3.
// - Each frame carries a 12-bit event vector from earlier stages and policers.
// - One global event mask per counter index, shared by all ports.
// - Event match is a nonzero AND of global mask and frame events.
// - Writing 1 to the clear control zeroes every counter and per-port sticky bit.
// - A counter considers a frame only if its priority mask bit is set.
// - Codes 0,1,2: clean no-match, clean match, errored match.
// - Codes 3,4,5: any match, errored no-match, any errored frame.
// - Byte select adds frame length, otherwise the counter adds one.
// - Each counter uses the ingress port's configuration, evaluated independently.
// - A frame without any destination counts as aborted, that is errored.
// - Each counter reads as a 32-bit low word and 8-bit high byte.
// - Low-word read captures the high byte; high read returns that capture.
// - Per-port sticky event bits hold until the global clear.
`timescale 1ns/1ns
module pstat_top #(
  parameter int NPORTS = 8,
  parameter int LEN_W = 14,
  parameter int ADDR_W = 12
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_frm_valid,
  input wire logic [$clog2(NPORTS)-1:0] i_frm_port,
  input wire logic [pstat_pkg::PRIO_W-1:0] i_frm_prio,
  input wire logic i_frm_error,
  input wire logic i_frm_no_dest,
  input wire logic [pstat_pkg::EVT_W-1:0] i_frm_events,
  input wire logic [LEN_W-1:0] i_frm_bytes,
  output logic o_irq
);

  localparam int PW = $clog2(NPORTS);
  localparam int NC = pstat_pkg::NCNT;
  localparam int CW = pstat_pkg::CNT_W;
  localparam logic [ADDR_W-1:0] PORT_END =
    ADDR_W'(pstat_pkg::ADDR_PORT_BASE) + ADDR_W'(NPORTS << pstat_pkg::PORT_STRIDE_SH);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (NPORTS < 2 || NPORTS > 48) begin : g_chk_ports
    $error("NPORTS must lie between 2 and 48");
  end
  if (LEN_W < 1 || LEN_W > 32 || ADDR_W < 12 || ADDR_W > 32) begin : g_chk_w
    $error("LEN_W or ADDR_W out of range");
  end

  // Byte-lane merge of a write into an existing word.
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [pstat_pkg::EVT_W-1:0] evt_mask_reg [NC];
  logic [pstat_pkg::CFG_W-1:0] cfg_reg [NPORTS*NC];
  logic [pstat_pkg::FLG_W-1:0] flags_reg [NPORTS];
  logic [pstat_pkg::IRQ_W-1:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_set;
  logic clr_busy_reg;
  logic [PW-1:0] clr_idx_reg;
  logic [31:0] pend_lo_reg;
  logic [7:0] shadow_hi_reg, sw_hi_reg;
  pstat_pkg::pstat_state_t st_reg;
  pstat_pkg::pstat_op_t sw_op_reg, s2_op_reg;
  logic [PW-1:0] sw_port_reg, s2_port_reg;
  logic [1:0] sw_cnt_reg;
  logic s2_valid_reg;
  logic [NC-1:0] s2_en_reg, q_en, s2_wrap;
  logic [LEN_W-1:0] s2_inc_reg [NC];
  logic [LEN_W-1:0] q_inc [NC];
  logic [pstat_pkg::ROW_W-1:0] row_new;
  logic [CW-1:0] cur_cnt [NC];

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  logic acc, aligned, hit_evt, hit_clr, hit_ist, hit_imk, hit_port;
  logic [ADDR_W-1:0] off;
  logic [PW-1:0] dec_port;
  logic [1:0] dec_sub, dec_cnt;
  logic [31:0] rd_val;
  logic clr_start, frame_take, sw_grant, err_eff, sw_done;

  // One access is decoded once, in the first access-phase cycle while idle.
  always_comb begin
    acc = i_psel && i_penable && !o_pready && (st_reg == pstat_pkg::ST_IDLE);
    aligned = (i_paddr[1:0] == 2'h0);
    off = i_paddr - ADDR_W'(pstat_pkg::ADDR_PORT_BASE);
    dec_port = off[pstat_pkg::PORT_STRIDE_SH +: PW];
    dec_sub = off[5:4];
    dec_cnt = off[3:2];
    hit_evt = aligned && (i_paddr < ADDR_W'(pstat_pkg::ADDR_CLR));
    hit_clr = aligned && (i_paddr == ADDR_W'(pstat_pkg::ADDR_CLR));
    hit_ist = aligned && (i_paddr == ADDR_W'(pstat_pkg::ADDR_IRQ_STAT));
    hit_imk = aligned && (i_paddr == ADDR_W'(pstat_pkg::ADDR_IRQ_MASK));
    hit_port = aligned && (i_paddr >= ADDR_W'(pstat_pkg::ADDR_PORT_BASE)) &&
               (i_paddr < PORT_END) &&
               !(dec_sub == pstat_pkg::SUB_FLAGS && dec_cnt != 2'h0);
  end

  // Read data for the registers that answer without the counter pipeline.
  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_evt) begin
      rd_val = 32'(evt_mask_reg[i_paddr[3:2]]);
    end else if (hit_clr) begin
      rd_val = 32'(clr_busy_reg);
    end else if (hit_ist) begin
      rd_val = 32'(irq_stat_reg);
    end else if (hit_imk) begin
      rd_val = 32'(irq_mask_reg);
    end else if (hit_port) begin
      unique case (dec_sub)
        pstat_pkg::SUB_CFG: rd_val = 32'(cfg_reg[{dec_port, dec_cnt}]);
        pstat_pkg::SUB_HI: rd_val = 32'(shadow_hi_reg);
        pstat_pkg::SUB_FLAGS: rd_val = 32'(flags_reg[dec_port]);
        pstat_pkg::SUB_LO: rd_val = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Global and per-port configuration registers
  // ----------------------------------------------------------------------
  // Event masks are global; port configuration is per port and counter.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int c = 0; c < NC; c++) begin
        evt_mask_reg[c] <= pstat_pkg::EVT_MASK_RST;
      end
      for (int k = 0; k < NPORTS*NC; k++) begin
        cfg_reg[k] <= pstat_pkg::CFG_RST;
      end
      irq_mask_reg <= pstat_pkg::IRQ_MASK_RST;
    end else if (acc && i_pwrite) begin
      if (hit_evt) begin
        evt_mask_reg[i_paddr[3:2]] <= pstat_pkg::EVT_W'(wmerge(
          32'(evt_mask_reg[i_paddr[3:2]]), i_pwdata, i_pstrb));
      end
      if (hit_imk) begin
        irq_mask_reg <= pstat_pkg::IRQ_W'(wmerge(32'(irq_mask_reg), i_pwdata, i_pstrb));
      end
      if (hit_port && dec_sub == pstat_pkg::SUB_CFG) begin
        cfg_reg[{dec_port, dec_cnt}] <= pstat_pkg::CFG_W'(wmerge(
          32'(cfg_reg[{dec_port, dec_cnt}]), i_pwdata, i_pstrb));
      end
    end
  end

  // ----------------------------------------------------------------------
  // Software counter access sequencer
  // ----------------------------------------------------------------------
  // Low reads and high writes need the counter row and so queue behind frames.
  assign sw_grant = (st_reg == pstat_pkg::ST_REQ) && !clr_busy_reg && !frame_take;
  assign sw_done = (st_reg == pstat_pkg::ST_WAIT) && s2_valid_reg &&
                   (s2_op_reg == pstat_pkg::OP_SW_RD || s2_op_reg == pstat_pkg::OP_SW_WR);

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= pstat_pkg::ST_IDLE;
      sw_op_reg <= pstat_pkg::OP_SW_RD;
      sw_port_reg <= '0;
      sw_cnt_reg <= 2'h0;
      sw_hi_reg <= 8'h00;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else if (o_pready) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      unique case (st_reg)
        pstat_pkg::ST_IDLE: begin
          if (acc) begin
            sw_port_reg <= dec_port;
            sw_cnt_reg <= dec_cnt;
            sw_hi_reg <= i_pstrb[0] ? i_pwdata[7:0] : 8'h00;
            if (hit_port && dec_sub == pstat_pkg::SUB_LO && !i_pwrite) begin
              sw_op_reg <= pstat_pkg::OP_SW_RD;
              st_reg <= pstat_pkg::ST_REQ;
            end else if (hit_port && dec_sub == pstat_pkg::SUB_HI && i_pwrite) begin
              sw_op_reg <= pstat_pkg::OP_SW_WR;
              st_reg <= pstat_pkg::ST_REQ;
            end else begin
              o_prdata <= i_pwrite ? 32'h0000_0000 : rd_val;
              o_pslverr <= !(hit_evt || hit_clr || hit_ist || hit_imk || hit_port);
              o_pready <= 1'b1;
            end
          end
        end
        pstat_pkg::ST_REQ: begin
          if (sw_grant) begin
            st_reg <= pstat_pkg::ST_WAIT;
          end
        end
        pstat_pkg::ST_WAIT: begin
          if (sw_done) begin
            o_prdata <= (s2_op_reg == pstat_pkg::OP_SW_RD) ?
                        cur_cnt[sw_cnt_reg][pstat_pkg::LO_W-1:0] : 32'h0000_0000;
            o_pready <= 1'b1;
            st_reg <= pstat_pkg::ST_IDLE;
          end
        end
        default: st_reg <= pstat_pkg::ST_IDLE;
      endcase
    end
  end

  // Low-word writes wait here; the high-byte read answers from the shadow.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_lo_reg <= 32'h0000_0000;
      shadow_hi_reg <= 8'h00;
    end else begin
      if (acc && i_pwrite && hit_port && dec_sub == pstat_pkg::SUB_LO) begin
        pend_lo_reg <= wmerge(pend_lo_reg, i_pwdata, i_pstrb);
      end
      if (sw_done && s2_op_reg == pstat_pkg::OP_SW_RD) begin
        shadow_hi_reg <= cur_cnt[sw_cnt_reg][CW-1:pstat_pkg::LO_W];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Statistics clear sweep
  // ----------------------------------------------------------------------
  // The sweep zeroes one port row per cycle; frames are not counted meanwhile.
  assign clr_start = acc && i_pwrite && hit_clr && i_pstrb[0] &&
                     i_pwdata[pstat_pkg::CLR_BIT] && !clr_busy_reg;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      clr_busy_reg <= 1'b0;
      clr_idx_reg <= '0;
    end else if (clr_start) begin
      clr_busy_reg <= 1'b1;
      clr_idx_reg <= '0;
    end else if (clr_busy_reg) begin
      clr_idx_reg <= clr_idx_reg + PW'(1);
      if (clr_idx_reg == PW'(NPORTS - 1)) begin
        clr_busy_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Stage 1: qualify the frame and choose the row to read
  // ----------------------------------------------------------------------
  pstat_mem_if #(.DW(pstat_pkg::ROW_W), .AW(PW)) mif ();

  assign frame_take = i_frm_valid && !clr_busy_reg && (32'(i_frm_port) < NPORTS);
  assign err_eff = i_frm_error || i_frm_no_dest;

  // The clear sweep wins over frames, and frames win over software.
  always_comb begin
    if (clr_busy_reg) begin
      mif.raddr = clr_idx_reg;
    end else if (frame_take) begin
      mif.raddr = i_frm_port;
    end else begin
      mif.raddr = sw_port_reg;
    end
  end

  for (genvar c = 0; c < NC; c++) begin : g_qual
    pstat_qual #(.LEN_W(LEN_W)) u_qual (
      .i_cfg(cfg_reg[{i_frm_port, 2'(c)}]),
      .i_evt_mask(evt_mask_reg[c]),
      .i_events(i_frm_events),
      .i_prio(i_frm_prio),
      .i_error(err_eff),
      .i_bytes(i_frm_bytes),
      .o_count(q_en[c]),
      .o_inc(q_inc[c])
    );
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      s2_valid_reg <= 1'b0;
      s2_op_reg <= pstat_pkg::OP_FRAME;
      s2_port_reg <= '0;
      s2_en_reg <= '0;
      for (int c = 0; c < NC; c++) begin
        s2_inc_reg[c] <= '0;
      end
    end else begin
      s2_valid_reg <= clr_busy_reg || frame_take || sw_grant;
      s2_port_reg <= mif.raddr;
      s2_en_reg <= (frame_take && !clr_busy_reg) ? q_en : '0;
      s2_inc_reg <= q_inc;
      if (clr_busy_reg) begin
        s2_op_reg <= pstat_pkg::OP_CLR;
      end else if (frame_take) begin
        s2_op_reg <= pstat_pkg::OP_FRAME;
      end else begin
        s2_op_reg <= sw_op_reg;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Stage 2: update the row and write it back
  // ----------------------------------------------------------------------
  // A 41-bit sum exposes the carry, which flags the wrap to zero.
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      logic [CW:0] sum;
      sum = '0;
      cur_cnt[c] = mif.rdata[c*CW +: CW];
      sum = {1'b0, cur_cnt[c]} + (CW+1)'(s2_inc_reg[c]);
      s2_wrap[c] = s2_en_reg[c] && sum[CW];
      row_new[c*CW +: CW] = s2_en_reg[c] ? sum[CW-1:0] : cur_cnt[c];
      if (s2_op_reg == pstat_pkg::OP_SW_WR && sw_cnt_reg == 2'(c)) begin
        row_new[c*CW +: CW] = {sw_hi_reg, pend_lo_reg};
      end
      if (s2_op_reg == pstat_pkg::OP_CLR) begin
        row_new[c*CW +: CW] = '0;
      end
    end
  end

  assign mif.we = s2_valid_reg && (s2_op_reg != pstat_pkg::OP_SW_RD);
  assign mif.waddr = s2_port_reg;
  assign mif.wdata = row_new;

  pstat_cnt_mem #(.DEPTH(NPORTS)) u_mem (
    .i_mclk(i_mclk),
    .mp(mif)
  );

  // ----------------------------------------------------------------------
  // Sticky event flags and interrupt
  // ----------------------------------------------------------------------
  // Flags set after the clear term, so a late frame event is never lost.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int p = 0; p < NPORTS; p++) begin
        flags_reg[p] <= '0;
      end
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        if (clr_start) begin
          flags_reg[p] <= '0;
        end
        if (s2_valid_reg && s2_op_reg == pstat_pkg::OP_FRAME && s2_port_reg == PW'(p)) begin
          flags_reg[p] <= (clr_start ? '0 : flags_reg[p]) |
                          {s2_wrap, s2_en_reg};
        end
      end
    end
  end

  // Status is cleared by its own read; a same-cycle event still sets it.
  always_comb begin
    irq_set = '0;
    irq_set[pstat_pkg::IRQ_WRAP_BIT] = |s2_wrap;
    irq_set[pstat_pkg::IRQ_CLRDONE_BIT] = clr_busy_reg && (clr_idx_reg == PW'(NPORTS - 1));
    irq_stat_next = ((acc && !i_pwrite && hit_ist) ? '0 : irq_stat_reg) | irq_set;
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_stat_reg <= '0;
      o_irq <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      o_irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

endmodule // pstat_top

// ### tb/pstat_assertions.sv
// Purpose: Port checks of the APB answers of the statistics block.
// Assumes: Requests are held until o_pready.
// Notes: Bound into pstat_top.
`timescale 1ns/1ns
module pstat_chk #(parameter int ADDR_W = 12, parameter int NPORTS = 8) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  logic acc_reg, first, glob, lo_rd;
  // Answer latency counts from the first access cycle only.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) acc_reg <= 1'b0;
    else acc_reg <= i_psel && i_penable;
  end
  assign first = i_psel && i_penable && !acc_reg;
  assign glob = i_paddr[ADDR_W-1:8] == '0;
  // Low reads above the last port are unmapped and answer at once.
  assign lo_rd = !glob && 32'(i_paddr) < 256 + NPORTS * 64 && !i_pwrite &&
                 i_paddr[5:4] == 2'h1 && i_paddr[1:0] == 2'h0;
  AST_RDY_PULSE: assert property (o_pready |=> !o_pready)
    else $error("long pready");
  AST_RDY_IN_ACC: assert property (o_pready |-> i_psel && i_penable)
    else $error("stray pready");
  AST_ERR_RDY: assert property (o_pslverr |-> o_pready)
    else $error("stray pslverr");
  AST_ERR_ZERO: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
    else $error("error read data");
  AST_MISALIGN: assert property (o_pready && i_paddr[1:0] != 2'h0 |-> o_pslverr)
    else $error("misaligned accepted");
  AST_SIMPLE: assert property (first && glob |=> o_pready)
    else $error("late simple answer");
  AST_LOW_LAT: assert property (first && lo_rd |=> !o_pready [*2])
    else $error("early low answer");
  AST_ANSWER: assert property (first |-> ##[1:300] o_pready)
    else $error("no answer");
  AST_HOLD: assert property (!o_pready |-> $stable(o_prdata))
    else $error("read data moved");
  cover property (first && lo_rd);
  cover property (o_pslverr);
  cover property (first && glob && i_pwrite);
endmodule // pstat_chk
bind pstat_top pstat_chk #(.ADDR_W(ADDR_W), .NPORTS(NPORTS)) u_pstat_chk (.i_mclk(i_mclk),
  .i_rstn(i_rstn),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));

// ### tb/pstat_frame_src.sv
// Purpose: Frame pipeline model feeding per-frame events.
// Assumes: Fields {port,prio,err,nodest,events,bytes}.
// Notes: Idle fields are inverted so stale values are never trusted.
`timescale 1ns/1ns
module pstat_frame_src (
  input wire logic i_mclk,
  output logic o_valid,
  output logic [33:0] o_fld
);
  initial begin
    o_valid = 1'b0;
    o_fld = 34'h0;
  end
  // One frame per edge; calls in a row stream frames back to back.
  task automatic send(input logic [33:0] f);
    @(posedge i_mclk);
    o_valid <= 1'b1;
    o_fld <= f;
  endtask
  // Ends a stream of frames.
  task automatic idle();
    @(posedge i_mclk);
    o_valid <= 1'b0;
    o_fld <= ~o_fld;
  endtask
endmodule // pstat_frame_src

// ### tb/testbench.sv
// Purpose: Self-checking bench of the port statistics block.
// Assumes: One APB transfer at a time; no frames during a clear.
// Notes: Counters are preset near wrap so wrapping is exercised.
`timescale 1ns/1ns
module testbench;
  logic i_mclk = 1'b0, i_rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, wst = 1'b0;
  logic er, pready, perr, irq, fv;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic [33:0] ff;
  logic [39:0] cnt[32];
  logic [12:0] cfg[32];
  logic [11:0] gm[4];
  logic [7:0] flg[8];
  // Count decision per code, indexed by {errored, matched}.
  logic [3:0] tt[8] = '{4'h1, 4'h2, 4'h8, 4'hA, 4'h4, 4'hC, 4'h0, 4'h0};
  integer miscompares = 0, num_checks = 0, seed = 32'h52C511AE;
  always #5 i_mclk = ~i_mclk;
  pstat_top u_pstat_top (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .i_pstrb(4'hF), .o_prdata(prd),
    .o_pready(pready), .o_pslverr(perr), .i_frm_valid(fv), .i_frm_port(ff[33:31]),
    .i_frm_prio(ff[30:28]), .i_frm_error(ff[27]), .i_frm_no_dest(ff[26]),
    .i_frm_events(ff[25:14]), .i_frm_bytes(ff[13:0]), .o_irq(irq));
  pstat_frame_src u_pstat_frame_src (.i_mclk(i_mclk), .o_valid(fv), .o_fld(ff));
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Held request; data taken at the edge that samples pready.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge i_mclk);
    pen <= 1'b1;
    do @(posedge i_mclk); while (pready !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  function automatic logic [11:0] adr(input int p, input int s, input int c);
    return 12'h100 + 12'(p * 64 + s * 16 + c * 4);
  endfunction
  task automatic clr();
    apb(1'b1, 12'h010, 32'h1);
    rd = 32'h1;
    repeat (50) if (rd[0] !== 1'b0) apb(1'b0, 12'h010, 32'h0);
    foreach (cnt[i]) cnt[i] = 40'h0;
    foreach (flg[i]) flg[i] = 8'h0;
  endtask
  task automatic check_all();
    logic [31:0] lo;
    for (int i = 0; i < 32; i++) begin
      apb(1'b0, adr(i / 4, 1, i % 4), 32'h0);
      lo = rd;
      apb(1'b0, adr(i / 4, 2, i % 4), 32'h0);
      chk({rd[7:0], lo}, cnt[i]);
      if (i % 4 == 3) apb(1'b0, adr(i / 4, 3, 0), 32'h0);
      if (i % 4 == 3) chk(40'(rd), 40'(flg[i / 4]));
    end
  endtask
  // Reference update of all four counters of the frame's port.
  task automatic frame();
    logic [33:0] f;
    logic [40:0] s;
    logic [12:0] g;
    int p;
    f = {2'($random(seed)), 32'($random(seed))};
    p = f[33:31];
    for (int c = 0; c < 4; c++) begin
      g = cfg[p * 4 + c];
      if (g[f[30:28]] && tt[g[10:8]][{f[27] | f[26], |(gm[c] & f[25:14])}]) begin
        s = {1'b0, cnt[p * 4 + c]} + (g[12] ? 41'(f[13:0]) : 41'h1);
        cnt[p * 4 + c] = s[39:0];
        flg[p][c] = 1'b1;
        flg[p][c + 4] = flg[p][c + 4] | s[40];
        wst = wst | s[40];
      end
    end
    u_pstat_frame_src.send(f);
  endtask
  task automatic end_of_test();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #300000;
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rstn <= 1'b1;
    apb(1'b0, 12'h018, 32'h0);
    chk(40'(rd), 40'h0);
    clr();
    apb(1'b0, 12'h014, 32'h0);
    chk(40'(rd), 40'h2);
    apb(1'b0, 12'h020, 32'h0);
    chk(40'(er), 40'h1);
    apb(1'b0, 12'h102, 32'h0);
    chk(40'(er), 40'h1);
    for (int c = 0; c < 4; c++) begin
      gm[c] = 12'($random(seed));
      apb(1'b1, 12'(c * 4), 32'(gm[c]));
      apb(1'b0, 12'(c * 4), 32'h0);
      chk(40'(rd), 40'(gm[c]));
    end
    for (int i = 0; i < 32; i++) begin
      cfg[i] = 13'($random(seed));
      cnt[i] = {28'hFFFFFFF, 12'($random(seed))};
      apb(1'b1, adr(i / 4, 0, i % 4), 32'(cfg[i]));
      apb(1'b1, adr(i / 4, 1, i % 4), cnt[i][31:0]);
      apb(1'b1, adr(i / 4, 2, i % 4), 32'(cnt[i][39:32]));
    end
    check_all();
    repeat (300) frame();
    u_pstat_frame_src.idle();
    check_all();
    apb(1'b1, 12'h018, 32'h1);
    repeat (3) @(posedge i_mclk);
    chk(40'(irq), 40'(wst));
    apb(1'b0, 12'h014, 32'h0);
    chk(40'(rd), 40'(wst));
    repeat (3) @(posedge i_mclk);
    chk(40'(irq), 40'h0);
    clr();
    check_all();
    end_of_test();
  end
endmodule // testbench
